// [rtc_calendar_events.sv]
// Real-time clock calendar, alarm, event flag and control registers on AHB-Lite.
`timescale 1ns/1ns

module rtc_calendar_events
    import rtc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        tick_32k,
    input  wire logic        ms_event,
    input  wire logic        sec_event,
    input  wire logic        min_event,
    input  wire logic        hour_tick,
    input  wire logic        wake_i,
    output logic             wake_o,
    output logic             wake_oe,
    output logic             rtc_irq,
    output logic             osc_enable,
    output logic      [3:0]  osc_res,
    output logic             corr_pulse,
    output logic             corr_add,
    output logic      [12:0] corr_ms
);

    // Increments a two-digit BCD value.
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        logic [7:0] r;
        r = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
        return r;
    endfunction : bcd_inc

    // Last day of a month in BCD; every year 2000-2099 divisible by four leaps.
    function automatic logic [5:0] month_len(input logic [4:0] m, input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        if (m == 5'h02) begin
            return leap ? 6'h29 : 6'h28;
        end
        if (m == 5'h04 || m == 5'h06 || m == 5'h09 || m == 5'h11) begin
            return 6'h30;
        end
        return 6'h31;
    endfunction : month_len

    logic [5:0]  hours, hours_alm, day, day_alm;
    logic [4:0]  month, month_alm;
    logic [7:0]  year, year_alm;
    logic [6:0]  flags, irq_en;
    logic        power_loss, match_d, wake_d, osc_pd, wake_dout, wake_dir;
    logic [15:0] correction_sign, key_lo, key_hi, pend_data;
    logic [13:0] pend_idx, wa_idx;
    logic        pend_valid, wphase;
    logic [1:0]  srst_cnt;

    // Bus decode and write staging toward the slow clock.
    wire        acc      = hsel & htrans[1] & hready & (hsize == 3'h2);
    wire [13:0] a_idx    = haddr[15:2];
    wire        apply    = tick_32k & pend_valid;
    wire        cap      = wphase & hreadyout;
    wire        busy     = (pend_valid & ~apply) | cap;
    wire        next_rdy = ~(((acc & hwrite) | (wphase & ~hreadyout)) & busy);
    wire        key_ok   = (key_lo == KEY_LO) && (key_hi == KEY_HI);
    wire        is_key   = (pend_idx == IDX_KEY_LO) || (pend_idx == IDX_KEY_HI);
    wire        wr_go    = apply & (key_ok | is_key);
    wire        rd_clr   = acc & ~hwrite & (a_idx == IDX_FLAGS || a_idx == IDX_PWR);

    // Per-register write strobes.
    wire wr_hours   = wr_go & (pend_idx == IDX_HOURS);
    wire wr_hours_a = wr_go & (pend_idx == IDX_HOURS_ALM);
    wire wr_day     = wr_go & (pend_idx == IDX_DAY);
    wire wr_day_a   = wr_go & (pend_idx == IDX_DAY_ALM);
    wire wr_month   = wr_go & (pend_idx == IDX_MONTH);
    wire wr_month_a = wr_go & (pend_idx == IDX_MONTH_ALM);
    wire wr_year    = wr_go & (pend_idx == IDX_YEAR);
    wire wr_year_a  = wr_go & (pend_idx == IDX_YEAR_ALM);
    wire wr_flags   = wr_go & (pend_idx == IDX_FLAGS);
    wire wr_en      = wr_go & (pend_idx == IDX_IRQ_EN);
    wire wr_correction_sign   = wr_go & (pend_idx == IDX_CORRECTION_SIGN);
    wire wr_osc     = wr_go & (pend_idx == IDX_OSC);
    wire wr_wake    = wr_go & (pend_idx == IDX_WAKE);
    wire srst       = wr_osc & pend_data[SRST_BIT];

    // calendar carries at the hour boundary.
    wire       hr_wrap   = hours == HOUR_LAST;
    wire       day_wrap  = day == month_len(month, year);
    wire       mon_wrap  = month == MONTH_LAST;
    wire [7:0] hours_inc = bcd_inc({2'h0, hours});
    wire [7:0] day_inc   = bcd_inc({2'h0, day});
    wire [7:0] month_inc = bcd_inc({3'h0, month});
    wire [5:0] next_hours = hr_wrap ? 6'h00 : hours_inc[5:0];
    wire [5:0] next_day   = day_wrap ? DAY_RST : day_inc[5:0];
    wire [4:0] next_month = mon_wrap ? MONTH_RST : month_inc[4:0];
    wire [7:0] next_year  = (year == YEAR_LAST) ? 8'h00 : bcd_inc(year);
    wire       day_step   = hour_tick & hr_wrap;
    wire       mon_step   = day_step & day_wrap;
    wire       year_step  = mon_step & mon_wrap;

    // alarm on the cycle the fields become equal.
    wire match     = {hours, day, month, year} == {hours_alm, day_alm, month_alm, year_alm};
    wire alarm_hit = match & ~match_d;
    // external event from the wake pin used as an input.
    wire ext_hit   = ~wake_dir & wake_i & ~wake_d;
    // set wins over a write-one clear.
    wire [6:0] ev_set    = {alarm_hit, ext_hit, day_step, hour_tick, min_event,
                            sec_event, ms_event};
    wire [6:0] ev_clr    = wr_flags ? {pend_data[ALARM_BIT], pend_data[EXT_BIT:0]} : 7'h00;
    wire [6:0] next_flags = (flags & ~ev_clr) | ev_set;

    // Read data selection; unmapped words read as zero.
    wire [15:0] rd_word =
        (a_idx == IDX_HOURS)     ? {10'h0, hours} :
        (a_idx == IDX_HOURS_ALM) ? {10'h0, hours_alm} :
        (a_idx == IDX_DAY)       ? {10'h0, day} :
        (a_idx == IDX_DAY_ALM)   ? {10'h0, day_alm} :
        (a_idx == IDX_MONTH)     ? {11'h0, month} :
        (a_idx == IDX_MONTH_ALM) ? {11'h0, month_alm} :
        (a_idx == IDX_YEAR)      ? {8'h0, year} :
        (a_idx == IDX_YEAR_ALM)  ? {8'h0, year_alm} :
        (a_idx == IDX_FLAGS)     ? {flags[6], 9'h0, flags[5:0]} :
        (a_idx == IDX_PWR)       ? {15'h0, power_loss} :
        (a_idx == IDX_IRQ_EN)    ? {irq_en[6], 9'h0, irq_en[5:0]} :
        (a_idx == IDX_CORRECTION_SIGN)     ? {correction_sign[15], 2'h0, correction_sign[12:0]} :
        (a_idx == IDX_OSC)       ? {srst_cnt != 2'h0, 10'h0, osc_pd, osc_res} :
        (a_idx == IDX_WAKE)      ? {11'h0, wake_dout, wake_dir, 3'h0} :
        (a_idx == IDX_KEY_LO)    ? key_lo :
        (a_idx == IDX_KEY_HI)    ? key_hi : 16'h0000;

    // AHB-Lite slave: reads answer at once, writes stall while one is staged.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            hrdata     <= 32'h0;
            wphase     <= 1'b0;
            wa_idx     <= 14'h0;
            pend_valid <= 1'b0;
            pend_idx   <= 14'h0;
            pend_data  <= 16'h0;
        end else begin
            hreadyout <= next_rdy;
            hresp     <= 1'b0;
            if (hreadyout) begin
                wphase <= acc & hwrite;
            end
            if (acc) begin
                wa_idx <= a_idx;
            end
            if (acc & ~hwrite) begin
                hrdata <= {16'h0, rd_word};
            end
            // staged write waits for the slow clock tick.
            if (cap) begin
                pend_valid <= 1'b1;
                pend_idx   <= wa_idx;
                pend_data  <= hwdata[15:0];
            end else if (apply) begin
                pend_valid <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            hours <= 6'h00;
            day   <= DAY_RST;
            month <= MONTH_RST;
            year  <= 8'h00;
            hours_alm <= 6'h00;
            day_alm   <= 6'h00;
            month_alm <= 5'h00;
            year_alm  <= 8'h00;
        end else if (srst) begin
            hours <= 6'h00;
            day   <= DAY_RST;
            month <= MONTH_RST;
            year  <= 8'h00;
            hours_alm <= 6'h00;
            day_alm   <= 6'h00;
            month_alm <= 5'h00;
            year_alm  <= 8'h00;
        end else begin
            if (wr_hours) begin
                hours <= pend_data[5:0];
            end else if (hour_tick) begin
                hours <= next_hours;
            end
            if (wr_day) begin
                day <= pend_data[5:0];
            end else if (day_step) begin
                day <= next_day;
            end
            if (wr_month) begin
                month <= pend_data[4:0];
            end else if (mon_step) begin
                month <= next_month;
            end
            if (wr_year) begin
                year <= pend_data[7:0];
            end else if (year_step) begin
                year <= next_year;
            end
            if (wr_hours_a) hours_alm <= pend_data[5:0];
            if (wr_day_a)   day_alm   <= pend_data[5:0];
            if (wr_month_a) month_alm <= pend_data[4:0];
            if (wr_year_a)  year_alm  <= pend_data[7:0];
        end
    end

    // Flags, enables, power-loss, correction and control fields.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            flags      <= 7'h00;
            irq_en     <= 7'h00;
            power_loss <= PWR_RST;
            correction_sign      <= 16'h0;
            osc_pd     <= 1'b0;
            osc_res    <= OSC_RES_RST;
            wake_dout  <= WAKE_DO_RST;
            wake_dir   <= WAKE_DR_RST;
            key_lo     <= 16'h0;
            key_hi     <= 16'h0;
        end else if (srst) begin
            flags      <= 7'h00;
            irq_en     <= 7'h00;
            power_loss <= 1'b0;
            correction_sign      <= 16'h0;
            osc_pd     <= 1'b0;
            osc_res    <= OSC_RES_RST;
            wake_dout  <= WAKE_DO_RST;
            wake_dir   <= WAKE_DR_RST;
            key_lo     <= 16'h0;
            key_hi     <= 16'h0;
        end else begin
            flags <= next_flags;
            if (wr_en) irq_en <= {pend_data[ALARM_BIT], pend_data[EXT_BIT:0]};
            // power-loss bit cleared by a read.
            if (rd_clr) power_loss <= 1'b0;
            if (wr_correction_sign) correction_sign <= {pend_data[SIGN_BIT], 2'h0, pend_data[12:0]};
            if (wr_osc) begin
                osc_pd  <= pend_data[OSC_PD_BIT];
                osc_res <= pend_data[3:0];
            end
            if (wr_wake) begin
                wake_dout <= pend_data[WAKE_DO_BIT];
                wake_dir  <= pend_data[WAKE_DR_BIT];
            end
            if (apply && pend_idx == IDX_KEY_LO) key_lo <= pend_data;
            if (apply && pend_idx == IDX_KEY_HI) key_hi <= pend_data;
        end
    end

    // Event edges, soft reset timer and registered outputs.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            match_d    <= 1'b0;
            wake_d     <= 1'b0;
            srst_cnt   <= 2'h0;
            rtc_irq    <= 1'b0;
            osc_enable <= 1'b1;
            wake_o     <= 1'b0;
            wake_oe    <= 1'b0;
            corr_pulse <= 1'b0;
            corr_add   <= 1'b0;
            corr_ms    <= 13'h0;
        end else begin
            match_d <= match;
            wake_d  <= wake_i;
            // bit reads set for three ticks, then clears itself.
            if (srst) begin
                srst_cnt <= SRST_TICKS;
            end else if (tick_32k && srst_cnt != 2'h0) begin
                srst_cnt <= srst_cnt - 2'h1;
            end
            rtc_irq    <= |(flags & irq_en);
            // oscillator runs while power-down is zero.
            osc_enable <= ~osc_pd;
            // open-drain drive low only as output with level zero.
            wake_o     <= 1'b0;
            wake_oe    <= wake_dir & ~wake_dout;
            // correction issued at the hour unless magnitude is zero.
            corr_pulse <= hour_tick & (correction_sign[12:0] != 13'h0);
            if (hour_tick) begin
                corr_add <= correction_sign[SIGN_BIT];
                corr_ms  <= correction_sign[12:0];
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_pwr_read_clear: assert property (rd_clr && !srst |=> !power_loss)
        else $error("power-loss bit not cleared by read");
    a_alarm_flag_set: assert property (alarm_hit |=> flags[6])
        else $error("alarm flag not set");
    a_alarm_flag_hold: assert property (flags[6] && !wr_flags && !srst |=> flags[6])
        else $error("alarm flag lost without clear");
    a_ext_flag_set: assert property (ext_hit |=> flags[5])
        else $error("external flag not set");
    a_irq_gate: assert property (rtc_irq == $past(|(flags & irq_en)))
        else $error("interrupt does not follow enabled flags");
    a_corr_value: assert property (hour_tick && correction_sign[12:0] != 13'h0
        |=> corr_pulse && corr_ms == $past(correction_sign[12:0]) && corr_add == $past(correction_sign[15]))
        else $error("hourly correction wrong");
    a_corr_zero: assert property (hour_tick && correction_sign[12:0] == 13'h0 |=> !corr_pulse)
        else $error("zero correction applied");
    a_soft_reset: assert property (srst |=> hours == 6'h00 && day == DAY_RST
        && month == MONTH_RST && !power_loss && srst_cnt == SRST_TICKS)
        else $error("soft reset did not restore fields");
    a_key_block: assert property (apply && !key_ok && !is_key && pend_idx == IDX_HOURS
        && !hour_tick |=> hours == $past(hours))
        else $error("locked write changed hours");
    a_hour_roll: assert property (hour_tick && hr_wrap && !wr_go && !srst
        |=> hours == 6'h00 && day == $past(next_day))
        else $error("hour rollover wrong");
    a_wake_drive: assert property (wake_dir && !wake_dout |=> wake_oe && !wake_o)
        else $error("wake pin not driven low");
    a_wake_input: assert property (!wake_dir |=> !wake_oe)
        else $error("wake pin driven as input");

endmodule : rtc_calendar_events

// [rtc_pkg.sv]
// Constants shared by the real-time clock calendar and event register block.
package rtc_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [13:0] IDX_HOURS     = 14'h1910;
    localparam logic [13:0] IDX_HOURS_ALM = 14'h1911;
    localparam logic [13:0] IDX_DAY       = 14'h1914;
    localparam logic [13:0] IDX_DAY_ALM   = 14'h1915;
    localparam logic [13:0] IDX_MONTH     = 14'h1918;
    localparam logic [13:0] IDX_MONTH_ALM = 14'h1919;
    localparam logic [13:0] IDX_YEAR      = 14'h191c;
    localparam logic [13:0] IDX_YEAR_ALM  = 14'h191d;
    localparam logic [13:0] IDX_FLAGS     = 14'h1920;
    localparam logic [13:0] IDX_PWR       = 14'h1921;
    localparam logic [13:0] IDX_IRQ_EN    = 14'h1924;
    localparam logic [13:0] IDX_CORRECTION_SIGN     = 14'h1928;
    localparam logic [13:0] IDX_OSC       = 14'h192c;
    localparam logic [13:0] IDX_WAKE      = 14'h1930;
    localparam logic [13:0] IDX_KEY_LO    = 14'h196c;
    localparam logic [13:0] IDX_KEY_HI    = 14'h196d;
    // Field positions.
    localparam int ALARM_BIT   = 15;
    localparam int EXT_BIT     = 5;
    localparam int SIGN_BIT    = 15;
    localparam int SRST_BIT    = 15;
    localparam int OSC_PD_BIT  = 4;
    localparam int WAKE_DO_BIT = 4;
    localparam int WAKE_DR_BIT = 3;
    // Reset values.
    localparam logic [5:0]  DAY_RST     = 6'h01;
    localparam logic [4:0]  MONTH_RST   = 5'h01;
    localparam logic [3:0]  OSC_RES_RST = 4'hb;
    localparam logic        PWR_RST     = 1'b1;
    localparam logic        WAKE_DO_RST = 1'b1;
    localparam logic        WAKE_DR_RST = 1'b0;
    // Write unlock key halves.
    localparam logic [15:0] KEY_LO = 16'hf1e0;
    localparam logic [15:0] KEY_HI = 16'h95a4;
    // Calendar limits in BCD.
    localparam logic [5:0]  HOUR_LAST  = 6'h23;
    localparam logic [4:0]  MONTH_LAST = 5'h12;
    localparam logic [7:0]  YEAR_LAST  = 8'h99;
    // Slow clock ticks for which the soft reset bit stays set.
    localparam logic [1:0]  SRST_TICKS = 2'h3;
endpackage : rtc_pkg

// [testbench.sv]
// Self-checking testbench for the real-time clock calendar and event register block.
`timescale 1ns/1ns
module testbench;
    import rtc_pkg::*;
    logic        mclk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, tick_32k = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic [3:0]  ev = 4'h0, osc_res;
    logic        wake_i = 1'b0, hready, hreadyout, hresp, wake_o, wake_oe, rtc_irq, osc_enable;
    logic        corr_pulse, corr_add, seen_corr;
    logic [12:0] corr_ms;
    int          num_errors = 0, n_tests = 0, tick_cnt = 0;
    assign hready = hreadyout;

    rtc_calendar_events dut (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tick_32k(tick_32k),
        .ms_event(ev[0]), .sec_event(ev[1]), .min_event(ev[2]), .hour_tick(ev[3]),
        .wake_i(wake_i), .wake_o(wake_o), .wake_oe(wake_oe), .rtc_irq(rtc_irq),
        .osc_enable(osc_enable), .osc_res(osc_res), .corr_pulse(corr_pulse),
        .corr_add(corr_add), .corr_ms(corr_ms));

    // The fast clock runs at 10 MHz.
    initial forever #50 mclk = ~mclk;

    // The slow tick pulses once every 305 fast cycles, close to the 32.768 kHz rate.
    always @(posedge mclk) begin
        tick_cnt <= (tick_cnt == 304) ? 0 : tick_cnt + 1;
        tick_32k <= (tick_cnt == 304);
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One single word transfer: address phase, then data phase, each held until hready.
    task automatic bus(input logic w, input logic [13:0] i, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        n = 0;
        hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; hsize <= 3'b010;
        haddr <= {16'h0, i, 2'b00};
        @(posedge mclk);
        while (hreadyout !== 1'b1 && n < 5000) begin @(posedge mclk); n++; end
        htrans <= 2'b00; hwdata <= d;
        @(posedge mclk);
        while (hreadyout !== 1'b1 && n < 5000) begin @(posedge mclk); n++; end
        r = hrdata;
        if (n >= 5000) num_errors++;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : bus

    task automatic wr(input logic [13:0] i, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, i, d, r);
    endtask : wr

    task automatic rchk(input logic [13:0] i, input logic [31:0] exp, input string nm);
        logic [31:0] r;
        bus(1'b0, i, 32'h0, r);
        chk(nm, exp, r);
    endtask : rchk

    // Waits for n slow ticks, then lets flags and the interrupt line settle.
    task automatic wait_ticks(input int n);
        repeat (n) begin
            @(posedge mclk);
            while (tick_32k !== 1'b1) @(posedge mclk);
        end
        repeat (3) @(posedge mclk);
    endtask : wait_ticks

    // Pulses event inputs for one cycle and records the correction strobe after it.
    task automatic pulse(input logic [3:0] v);
        ev <= v;
        @(posedge mclk);
        ev <= 4'h0;
        @(posedge mclk);
        seen_corr = corr_pulse;
        repeat (2) @(posedge mclk);
    endtask : pulse

    task automatic unlock;
        wr(IDX_KEY_LO, {16'h0, KEY_LO});
        wr(IDX_KEY_HI, {16'h0, KEY_HI});
        wait_ticks(2);
    endtask : unlock

    task automatic hw_reset;
        reset <= 1'b1;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
    endtask : hw_reset

    task automatic t_reset_vals;
        logic [13:0] ri [13] = '{IDX_HOURS, IDX_HOURS_ALM, IDX_DAY, IDX_DAY_ALM, IDX_MONTH,
            IDX_MONTH_ALM, IDX_YEAR, IDX_YEAR_ALM, IDX_IRQ_EN, IDX_CORRECTION_SIGN, IDX_OSC, IDX_WAKE,
            14'h1934};
        logic [31:0] rv [13] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0,
            32'h0, 32'h0, 32'hb, 32'h10, 32'h0};
        rchk(IDX_PWR, 32'h1, "power loss at reset");
        rchk(IDX_PWR, 32'h0, "power loss after read");
        for (int k = 0; k < 13; k++) rchk(ri[k], rv[k], "reset value");
        chk("osc pins", 32'h1b, {27'h0, osc_enable, osc_res});
        chk("wake oe", 32'h0, {31'h0, wake_oe});
    endtask : t_reset_vals

    task automatic t_gate;
        wr(IDX_HOURS, 32'h12);
        wait_ticks(2);
        rchk(IDX_HOURS, 32'h0, "locked write");
        unlock();
    endtask : t_gate

    task automatic t_calendar;
        wait_ticks(1);
        wr(IDX_HOURS, 32'h23);
        rchk(IDX_HOURS, 32'h0, "hours before tick");
        wr(IDX_DAY_ALM, 32'h02);
        wr(IDX_MONTH_ALM, 32'h01);
        wait_ticks(2);
        rchk(IDX_HOURS, 32'h23, "hours written");
        pulse(4'b1000);
        chk("no correction", 32'h0, {31'h0, seen_corr});
        rchk(IDX_HOURS, 32'h0, "hours wrap");
        rchk(IDX_DAY, 32'h02, "day step");
        rchk(IDX_FLAGS, 32'h8018, "alarm day hour flags");
        wr(IDX_MONTH, 32'h12);
        wr(IDX_DAY, 32'h31);
        wr(IDX_HOURS, 32'h23);
        wr(IDX_YEAR, 32'h19);
        wait_ticks(2);
        pulse(4'b1000);
        rchk(IDX_DAY, 32'h01, "day wrap");
        rchk(IDX_MONTH, 32'h01, "month wrap");
        rchk(IDX_YEAR, 32'h20, "year step");
    endtask : t_calendar

    task automatic t_correction_sign;
        wr(IDX_CORRECTION_SIGN, 32'hf123);
        wait_ticks(2);
        rchk(IDX_CORRECTION_SIGN, 32'h9123, "correction_sign reserved bits");
        wr(IDX_CORRECTION_SIGN, 32'h8123);
        wait_ticks(2);
        pulse(4'b1000);
        chk("add strobe", 32'h6123, {seen_corr, corr_add, corr_ms});
        wr(IDX_CORRECTION_SIGN, 32'h0045);
        wait_ticks(2);
        pulse(4'b1000);
        chk("sub strobe", 32'h4045, {seen_corr, corr_add, corr_ms});
    endtask : t_correction_sign

    task automatic t_events;
        wr(IDX_FLAGS, 32'h803f);
        wait_ticks(2);
        rchk(IDX_FLAGS, 32'h0, "flags cleared");
        pulse(4'b0111);
        rchk(IDX_FLAGS, 32'h7, "periodic flags");
        chk("irq masked", 32'h0, {31'h0, rtc_irq});
        wr(IDX_IRQ_EN, 32'h2);
        wait_ticks(2);
        chk("irq seconds", 32'h1, {31'h0, rtc_irq});
        wr(IDX_FLAGS, 32'h2);
        wait_ticks(2);
        rchk(IDX_FLAGS, 32'h5, "one flag cleared");
        chk("irq after clear", 32'h0, {31'h0, rtc_irq});
    endtask : t_events

    task automatic t_osc_wake;
        wr(IDX_OSC, 32'h18);
        wr(IDX_WAKE, 32'h08);
        wait_ticks(2);
        chk("osc pins", 32'h08, {27'h0, osc_enable, osc_res});
        chk("wake low", 32'h1, {31'h0, wake_oe});
        chk("wake level", 32'h0, {31'h0, wake_o});
        wr(IDX_WAKE, 32'h18);
        wait_ticks(2);
        chk("wake released", 32'h0, {31'h0, wake_oe});
        // The released pin is pulled high; as an output it must raise no event.
        wake_i <= 1'b1;
        repeat (3) @(posedge mclk);
        wake_i <= 1'b0;
        rchk(IDX_FLAGS, 32'h5, "no event as output");
        wr(IDX_WAKE, 32'h10);
        wr(IDX_IRQ_EN, 32'h20);
        wr(IDX_FLAGS, 32'h5);
        wait_ticks(2);
        wake_i <= 1'b1;
        repeat (3) @(posedge mclk);
        rchk(IDX_FLAGS, 32'h20, "external flag");
        chk("irq external", 32'h1, {31'h0, rtc_irq});
        wake_i <= 1'b0;
    endtask : t_osc_wake

    task automatic t_resets;
        hw_reset();
        rchk(IDX_FLAGS, 32'h0, "flags after reset");
        rchk(IDX_PWR, 32'h0, "power loss after flag read");
        unlock();
        wr(IDX_HOURS, 32'h15);
        wr(IDX_OSC, 32'h8000);
        wait_ticks(5);
        rchk(IDX_OSC, 32'hb, "soft reset bit");
        rchk(IDX_HOURS, 32'h0, "hours after soft reset");
        rchk(IDX_PWR, 32'h0, "power loss after soft reset");
        wr(IDX_HOURS, 32'h07);
        wait_ticks(2);
        rchk(IDX_HOURS, 32'h0, "key cleared");
    endtask : t_resets

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    // Watchdog: the scenarios need well under this many cycles.
    initial begin
        repeat (90000) @(posedge mclk);
        num_errors++;
        tally_and_finish();
    end

    // Main sequence.
    initial begin
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        t_reset_vals();
        t_gate();
        t_calendar();
        t_correction_sign();
        t_events();
        t_osc_wake();
        t_resets();
        tally_and_finish();
    end
endmodule : testbench
